//--- design/ppw_pkg.sv
/*
 pulse width meter package: variant timing, request and result carriers.
 assumes a 100 MHz system clock; time unit and limit chosen by variant parameter.
*/
`default_nettype none
package ppw_pkg;
   localparam int CLK_PERIOD_PS = 10000;
   // time units in picoseconds, one per variant
   localparam int UNIT_PS_V0 = 10000000;
   localparam int UNIT_PS_V1 = 2000000;
   localparam int UNIT_PS_V2 = 800000;
   localparam int UNIT_PS_V3 = 810000;
   localparam int UNIT_CYC_V0 = UNIT_PS_V0 / CLK_PERIOD_PS;
   localparam int UNIT_CYC_V1 = UNIT_PS_V1 / CLK_PERIOD_PS;
   localparam int UNIT_CYC_V2 = UNIT_PS_V2 / CLK_PERIOD_PS;
   localparam int UNIT_CYC_V3 = UNIT_PS_V3 / CLK_PERIOD_PS;
   localparam int CNT_W = 16;
   localparam int PIN_W = 4;
   localparam int PIN_N = 16;
   localparam int DIV_W = 11;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_RST = 11'h000;

   typedef enum logic [1:0] {
      PPW_IDLE = 2'b00,
      PPW_ARM = 2'b01,
      PPW_WAIT = 2'b10,
      PPW_MEAS = 2'b11
   } ppw_state_t;

   typedef struct packed {
      logic valid;
      logic [PIN_W-1:0] pin;
      logic polarity;
      logic byte_dest;
   } ppw_req_t;

   typedef struct packed {
      logic done;
      logic [CNT_W-1:0] width;
   } ppw_res_t;

   typedef struct packed {
      ppw_state_t state;
      logic [PIN_W-1:0] pin;
      logic polarity;
      logic byte_dest;
      logic sync1;
      logic sync2;
      logic prev;
      logic [DIV_W-1:0] div;
      logic [CNT_W-1:0] cnt;
      logic done;
      logic [CNT_W-1:0] width;
      logic [PIN_N-1:0] in_mode;
   } ppw_regs_t;

   localparam logic [PIN_N-1:0] IN_MODE_RST = 16'h0000;
endpackage
`default_nettype wire

//--- design/ppw_meter.sv
/*
 pulse width meter: measures one high or low pulse on a selected pin.
 assumes pins are synchronous to ref_clk_i and the requester waits for done.
 a request made while busy is dropped without notice; a zero result means a timeout,
 a pulse no longer than one unit, or a byte result that wrapped to zero.
*/
`timescale 1ns/1ns
`default_nettype none
module ppw_meter
   import ppw_pkg::*;
#(
   parameter int VARIANT = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // request from the interpreter
   input wire ppw_req_t req_i,
   output logic busy_o,
   // pins
   input wire logic [PIN_N-1:0] pin_i,
   output logic [PIN_N-1:0] pin_in_mode_o,
   // result
   output ppw_res_t res_o
);

   // last divider count of a time unit (cycles per unit minus one) for the chosen variant
   function automatic logic [DIV_W-1:0] unit_cycles(input int v);
      int c;
      case (v)
         0: c = UNIT_CYC_V0;
         2: c = UNIT_CYC_V2;
         3: c = UNIT_CYC_V3;
         default: c = UNIT_CYC_V1;
      endcase
      return DIV_W'(c - 1);
   endfunction

   localparam logic [DIV_W-1:0] DIV_LAST = unit_cycles(VARIANT);

   // level of the selected pin; only this one bit enters the synchroniser,
   // so a pin switched by a new request is flushed by the arming unit
   function automatic logic pick_pin(input logic [PIN_N-1:0] pins,
      input logic [PIN_W-1:0] sel);
      logic level;
      level = pins[sel];
      return level;
   endfunction

   // pin mask with the newly selected pin turned to input; bits never clear
   function automatic logic [PIN_N-1:0] add_input(input logic [PIN_N-1:0] mode,
      input logic [PIN_W-1:0] sel);
      logic [PIN_N-1:0] mask;
      mask = PIN_N'(1) << sel;
      return mode | mask;
   endfunction

   // transition into the given level between two successive synchronised samples;
   // start and end share it, so both are late by the same two cycles
   function automatic logic edge_into(input logic prev_lvl, input logic cur_lvl,
      input logic want);
      logic hit;
      hit = (prev_lvl != want) && (cur_lvl == want);
      return hit;
   endfunction

   // divider wraps once per time unit, so counts are quantised to whole units
   function automatic logic [DIV_W-1:0] next_div(input logic [DIV_W-1:0] div);
      logic [DIV_W-1:0] nd;
      if (div == DIV_LAST) begin
         nd = DIV_RST;
      end else begin
         nd = div + 1'b1;
      end
      return nd;
   endfunction

   // a byte destination keeps only the low byte: a long pulse wraps, never clips
   function automatic logic [CNT_W-1:0] trim_result(input logic [CNT_W-1:0] cnt,
      input logic byte_dest);
      logic [CNT_W-1:0] res;
      if (byte_dest) begin
         res = {8'h00, cnt[7:0]};
      end else begin
         res = cnt;
      end
      return res;
   endfunction

   // result out, one-cycle completion pulse, back to idle
   function automatic ppw_regs_t finish(input ppw_regs_t r,
      input logic [CNT_W-1:0] width);
      ppw_regs_t f;
      f = r;
      f.width = width;
      f.done = 1'b1;
      f.state = PPW_IDLE;
      return f;
   endfunction

   // one more unit elapsed; a full counter means the window ran out and the
   // result is zero, so a missing or stuck pulse can never stall the requester
   function automatic ppw_regs_t unit_step(input ppw_regs_t r,
      input logic [CNT_W-1:0] cnt);
      ppw_regs_t f;
      if (cnt == CNT_MAX) begin
         f = finish(r, CNT_RST);
      end else begin
         f = r;
         f.cnt = cnt + 1'b1;
      end
      return f;
   endfunction

   ppw_regs_t r_q;
   ppw_regs_t r_d;
   logic accept;
   logic tick;
   logic pin_sel;
   logic edge_start;
   logic edge_end;

   // a request is taken only in idle; one made while busy is dropped silently
   assign accept = req_i.valid && (r_q.state == PPW_IDLE);
   assign tick = (r_q.div == DIV_LAST);
   assign pin_sel = pick_pin(pin_i, r_q.pin);
   // start edge: from the idle level into the pulse level
   assign edge_start = edge_into(r_q.prev, r_q.sync2, r_q.polarity);
   // end edge: back out of the pulse level
   assign edge_end = edge_into(r_q.prev, r_q.sync2, !r_q.polarity);

   // state walk: idle takes a request, arm spends one whole unit so that the
   // synchroniser holds only the new pin, wait looks for the start edge and
   // measure counts units until the end edge; both give up on a full counter
   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      // selected pin passes through two flops before anyone looks at it
      r_d.sync1 = pin_sel;
      r_d.sync2 = r_q.sync1;
      r_d.prev = r_q.sync2;
      r_d.div = next_div(r_q.div);
      case (r_q.state)
         PPW_IDLE: begin
            if (accept) begin
               r_d.pin = req_i.pin;
               r_d.polarity = req_i.polarity;
               r_d.byte_dest = req_i.byte_dest;
               r_d.in_mode = add_input(r_q.in_mode, req_i.pin);
               // a full unit of arming flushes samples of the previous pin
               r_d.div = DIV_RST;
               r_d.state = PPW_ARM;
            end
         end
         PPW_ARM: begin
            // let the synchroniser fill with the newly selected pin
            if (tick) begin
               r_d.cnt = CNT_RST;
               r_d.state = PPW_WAIT;
            end
         end
         PPW_WAIT: begin
            // a pin already at pulse level is no start: a real edge is needed
            if (edge_start) begin
               r_d.cnt = CNT_RST;
               r_d.div = DIV_RST;
               r_d.state = PPW_MEAS;
            end else if (tick) begin
               r_d = unit_step(r_d, r_q.cnt);
            end
         end
         PPW_MEAS: begin
            // an end edge on a tick wins, so the count is the floor of the width, or one less for a whole number of units
            if (edge_end) begin
               r_d = finish(r_d, trim_result(r_q.cnt, r_q.byte_dest));
            end else if (tick) begin
               r_d = unit_step(r_d, r_q.cnt);
            end
         end
         default: r_d.state = PPW_IDLE;
      endcase
   end

   // only constants in reset; the synchroniser starts low like an idle input
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r_q.state <= PPW_IDLE;
         r_q.pin <= 4'h0;
         r_q.polarity <= 1'b0;
         r_q.byte_dest <= 1'b0;
         r_q.sync1 <= 1'b0;
         r_q.sync2 <= 1'b0;
         r_q.prev <= 1'b0;
         r_q.div <= DIV_RST;
         r_q.cnt <= CNT_RST;
         r_q.done <= 1'b0;
         r_q.width <= CNT_RST;
         r_q.in_mode <= IN_MODE_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // handshake out straight from the state; data outputs come from flops only
   assign busy_o = (r_q.state != PPW_IDLE);
   assign pin_in_mode_o = r_q.in_mode;
   assign res_o = {r_q.done, r_q.width};

endmodule // ppw_meter
`default_nettype wire

//--- test/ppw_monitor.sv
/*
 port checker for the pulse width meter.
 assumes one clock domain; bound to every ppw_meter.
*/
`timescale 1ns/1ns
`default_nettype none
module ppw_monitor
   import ppw_pkg::*;
(
   // watched ports
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire ppw_req_t req_i,
   input wire logic busy_o,
   input wire logic [PIN_N-1:0] pin_i,
   input wire logic [PIN_N-1:0] pin_in_mode_o,
   input wire ppw_res_t res_o
);
   logic acc;
   logic byte_q;
   assign acc = req_i.valid && !busy_o;
   // remembers the destination size of the running request
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) byte_q <= 1'b0;
      else if (acc) byte_q <= req_i.byte_dest;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   take_busy_a: assert property (acc |=> busy_o)
      else $error("busy not raised");
   done_free_a: assert property (res_o.done |-> !busy_o)
      else $error("busy at done");
   done_once_a: assert property (res_o.done |=> !res_o.done)
      else $error("done too long");
   set_mode_a: assert property (acc |=> pin_in_mode_o[$past(req_i.pin)])
      else $error("pin not input");
   mode_keep_a: assert property ((pin_in_mode_o & $past(pin_in_mode_o))
      == $past(pin_in_mode_o)) else $error("input mode lost");
   width_hold_a: assert property (!res_o.done |-> $stable(res_o.width))
      else $error("width moved");
   byte_high_a: assert property (res_o.done && byte_q |-> res_o.width[15:8] == 8'h00)
      else $error("upper byte set");
   sync_wait_a: assert property (acc |=> !res_o.done [*8])
      else $error("done too early");
endmodule // ppw_monitor
bind ppw_meter ppw_monitor mon (.ref_clk_i, .resetn_i, .req_i, .busy_o, .pin_i,
   .pin_in_mode_o, .res_o);
`default_nettype wire

//--- test/ppw_src.sv
/*
 pulse source on the pin bus.
 assumes it is called from the bench right after the request, while the meter is still arming.
*/
`timescale 1ns/1ns
`default_nettype none
module ppw_src
   import ppw_pkg::*;
(
   // clock and pins
   input wire logic ref_clk_i,
   output logic [PIN_N-1:0] pin_o
);
   initial pin_o = 16'h0000;
   // idle wait is longer than one arming unit, so the start edge is not missed
   task automatic pulse(input logic [PIN_W-1:0] p, input logic pol, input int n);
      pin_o = {PIN_N{!pol}};
      repeat (100) @(negedge ref_clk_i);
      pin_o[p] = pol;
      repeat (n) @(negedge ref_clk_i);
      pin_o[p] = !pol;
   endtask
endmodule // ppw_src
`default_nettype wire

//--- test/tb_pin_pulse_width_meter.sv
/*
 bench for the pulse width meter, variant with 80-cycle units.
 assumes a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_pin_pulse_width_meter;
   import ppw_pkg::*;
   localparam int U = UNIT_CYC_V2;
   logic ref_clk_i;
   logic resetn_i;
   ppw_req_t req_i;
   logic busy_o;
   logic [PIN_N-1:0] pin_i;
   logic [PIN_N-1:0] mode;
   ppw_res_t res_o;
   int n_fail;
   int checked;
   ppw_meter #(.VARIANT(2)) dut (.ref_clk_i, .resetn_i, .req_i, .busy_o, .pin_i,
      .pin_in_mode_o(mode), .res_o);
   ppw_src src (.ref_clk_i, .pin_o(pin_i));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic meas(input logic [3:0] p, input logic pol, input logic b, input int n,
      input logic [15:0] e);
      int k;
      @(negedge ref_clk_i);
      req_i = '{1'b1, p, pol, b};
      @(negedge ref_clk_i);
      req_i.valid = 1'b0;
      src.pulse(p, pol, n);
      k = 0;
      while (res_o.done !== 1'b1 && k < 200) begin
         @(posedge ref_clk_i);
         #1 k++;
      end
      chk({15'h0000, res_o.done}, 16'h0001);
      chk(res_o.width, e);
   endtask
   task automatic high_word;
      meas(4'h3, 1'b1, 1'b0, 10 * U + 40, 16'h000A);
   endtask
   task automatic low_byte;
      meas(4'hF, 1'b0, 1'b1, 300 * U + 40, 16'h002C);
   endtask
   task automatic short_zero;
      meas(4'h0, 1'b1, 1'b0, U / 2, 16'h0000);
      chk(mode, 16'h8009);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      resetn_i = 1'b0;
      req_i = '0;
      n_fail = 0;
      checked = 0;
      repeat (2) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      high_word();
      low_byte();
      short_zero();
      end_of_test();
   end
   initial begin
      #400000 n_fail++;
      end_of_test();
   end
endmodule // tb_pin_pulse_width_meter
`default_nettype wire
